//--- rtl/tec_config_lock.sv
// Configuration, lock and alert output logic of the module temperature sensor
`timescale 1ns/10ps
module tec_config_lock
  import tec_pkg::*;
#(
  parameter int unsigned PWRUP_CNT = PWRUP_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic [2:0]  addr_pins,
  input  wire logic        supply_ok,
  input  wire logic        auto_off_fuse,
  input  wire logic        crit_event,
  input  wire logic        window_event,
  input  wire logic [15:0] temp_value,
  output logic             alert_o,
  output logic             alert_oe,
  output logic             sensor_powerdown,
  output tec_trip_t        trip_limits
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic        scl_s1;
  logic        scl_s2;
  logic        scl_s3;
  logic        sda_s1;
  logic        sda_s2;
  logic        sda_s3;
  logic [2:0]  addr_s1;
  logic [2:0]  addr_s2;

  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic        addr_hit;
  logic        byte_done;

  tec_phase_t  phase;
  logic [3:0]  bit_cnt;
  logic [2:0]  byte_idx;
  logic        rd_mode;
  logic        nack;
  logic        tx_lo;
  logic [7:0]  shreg;
  logic [7:0]  tx_byte;
  logic [15:0] rd_word;
  logic [15:0] rd_mux;

  logic [7:0]  ptr;
  logic [7:0]  wr_hi;
  logic        wr_valid;
  tec_wreq_t   wreq;

  logic        ct_lock;
  logic        aw_lock;
  logic        shutdown;
  logic        out_en;
  logic        crit_only;
  logic        polarity;
  logic        mode_int;
  logic        locked;
  logic        cfg_wr;
  logic        force_off;

  logic        ev_src;
  logic        ev_src_q;
  logic        pending;
  logic        alert_act;
  logic        alert_status;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Locked trip registers keep their value; reserved bits stay zero
  function automatic logic [15:0] trip_next(input logic [15:0] old,
                                            input logic [15:0] data,
                                            input logic        lock);
    trip_next = lock ? old : (data & TRIP_MASK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_s1  <= 1'b1;
      scl_s2  <= 1'b1;
      scl_s3  <= 1'b1;
      sda_s1  <= 1'b1;
      sda_s2  <= 1'b1;
      sda_s3  <= 1'b1;
      addr_s1 <= 3'h0;
      addr_s2 <= 3'h0;
    end else begin
      scl_s1  <= scl_i;
      scl_s2  <= scl_s1;
      scl_s3  <= scl_s2;
      sda_s1  <= sda_i;
      sda_s2  <= sda_s1;
      sda_s3  <= sda_s2;
      addr_s1 <= addr_pins;
      addr_s2 <= addr_s1;
    end
  end

  assign scl_rise   = scl_s2 & ~scl_s3;
  assign scl_fall   = ~scl_s2 & scl_s3;
  assign start_cond = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  assign stop_cond  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  assign addr_hit   = (shreg[7:1] == {BUS_ADDR_HI, addr_s2});
  assign byte_done  = scl_fall & (phase == TEC_RECV) & (bit_cnt == BITS_PER_BYTE);

  ////////////////////////////////////////////////////////////////////////////
  // Two-wire slave sequencer

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase    <= TEC_IDLE;
      bit_cnt  <= 4'h0;
      byte_idx <= BYTE_ADDR;
      rd_mode  <= 1'b0;
      nack     <= 1'b0;
      tx_lo    <= 1'b0;
      shreg    <= 8'h00;
      tx_byte  <= 8'h00;
      rd_word  <= 16'h0000;
      sda_oe   <= 1'b0;
    end else if (start_cond) begin
      // Repeated start restarts the address phase
      phase    <= TEC_RECV;
      bit_cnt  <= 4'h0;
      byte_idx <= BYTE_ADDR;
      sda_oe   <= 1'b0;
    end else if (stop_cond) begin
      phase  <= TEC_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      case (phase)
        TEC_RECV: begin
          shreg   <= {shreg[6:0], sda_s2};
          bit_cnt <= bit_cnt + 4'h1;
        end
        TEC_MACK: begin
          nack <= sda_s2;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (phase)
        TEC_RECV: begin
          if (bit_cnt == BITS_PER_BYTE) begin
            if ((byte_idx == BYTE_ADDR) && !addr_hit) begin
              phase <= TEC_IDLE;
            end else begin
              phase  <= TEC_ACK;
              sda_oe <= 1'b1;
              if (byte_idx == BYTE_ADDR) begin
                rd_mode <= shreg[0];
              end
            end
          end
        end
        TEC_ACK: begin
          bit_cnt <= 4'h0;
          if ((byte_idx == BYTE_ADDR) && rd_mode) begin
            // Snapshot the word so both bytes come from one instant
            phase   <= TEC_SEND;
            rd_word <= rd_mux;
            tx_byte <= rd_mux[15:8];
            tx_lo   <= 1'b1;
            sda_oe  <= ~rd_mux[15];
          end else begin
            phase  <= TEC_RECV;
            sda_oe <= 1'b0;
            if (byte_idx != BYTE_EXTRA) begin
              byte_idx <= byte_idx + 3'h1;
            end
          end
        end
        TEC_SEND: begin
          if (bit_cnt == LAST_TX_BIT) begin
            phase  <= TEC_MACK;
            sda_oe <= 1'b0;
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
            tx_byte <= {tx_byte[6:0], 1'b0};
            sda_oe  <= ~tx_byte[6];
          end
        end
        TEC_MACK: begin
          if (nack) begin
            phase <= TEC_IDLE;
          end else begin
            phase   <= TEC_SEND;
            bit_cnt <= 4'h0;
            tx_lo   <= ~tx_lo;
            tx_byte <= tx_lo ? rd_word[7:0] : rd_word[15:8];
            sda_oe  <= tx_lo ? ~rd_word[7] : ~rd_word[15];
          end
        end
        default: begin
          phase <= TEC_IDLE;
        end
      endcase
    end
  end

  // Open-drain data line only ever pulls low
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer and write request capture

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr      <= PTR_RESET;
      wr_hi    <= 8'h00;
      wr_valid <= 1'b0;
      wreq     <= '0;
    end else begin
      wr_valid <= 1'b0;
      if (byte_done) begin
        case (byte_idx)
          BYTE_PTR: begin
            ptr <= shreg;
          end
          BYTE_DATA_HI: begin
            wr_hi <= shreg;
          end
          BYTE_DATA_LO: begin
            wr_valid  <= 1'b1;
            wreq.ptr  <= ptr;
            wreq.data <= {wr_hi, shreg};
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer

  always_comb begin
    rd_mux = 16'h0000;
    case (ptr)
      PTR_CONFIG: begin
        rd_mux[CFG_SHUTDOWN]  = shutdown;
        rd_mux[CFG_CT_LOCK]   = ct_lock;
        rd_mux[CFG_AW_LOCK]   = aw_lock;
        rd_mux[CFG_CLEAR]     = 1'b0;
        rd_mux[CFG_STATUS]    = alert_status;
        rd_mux[CFG_OUT_EN]    = out_en;
        rd_mux[CFG_CRIT_ONLY] = crit_only;
        rd_mux[CFG_POLARITY]  = polarity;
        rd_mux[CFG_MODE]      = mode_int;
      end
      PTR_UPPER: begin
        rd_mux = trip_limits.upper;
      end
      PTR_LOWER: begin
        rd_mux = trip_limits.lower;
      end
      PTR_CRIT: begin
        rd_mux = trip_limits.critical;
      end
      PTR_TEMP: begin
        rd_mux = temp_value;
      end
      default: begin
        rd_mux = 16'h0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trip limit registers

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      trip_limits.upper    <= TRIP_RESET;
      trip_limits.lower    <= TRIP_RESET;
      trip_limits.critical <= TRIP_RESET;
    end else if (wr_valid) begin
      case (wreq.ptr)
        PTR_UPPER: begin
          trip_limits.upper <= trip_next(trip_limits.upper, wreq.data, aw_lock);
        end
        PTR_LOWER: begin
          trip_limits.lower <= trip_next(trip_limits.lower, wreq.data, aw_lock);
        end
        PTR_CRIT: begin
          trip_limits.critical <= trip_next(trip_limits.critical, wreq.data, ct_lock);
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration bits

  assign cfg_wr = wr_valid & (wreq.ptr == PTR_CONFIG);
  assign locked = ct_lock | aw_lock;

  tec_pwrup_timer #(
    .CNT (PWRUP_CNT)
  ) u_pwrup (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .fuse_in   (auto_off_fuse),
    .supply_in (supply_ok),
    .force_off (force_off)
  );

  // Locks are sticky: only the power-on reset clears them
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ct_lock <= 1'b0;
      aw_lock <= 1'b0;
    end else if (cfg_wr) begin
      ct_lock <= ct_lock | wreq.data[CFG_CT_LOCK];
      aw_lock <= aw_lock | wreq.data[CFG_AW_LOCK];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_en    <= 1'b0;
      crit_only <= 1'b0;
      polarity  <= 1'b0;
      mode_int  <= 1'b0;
    end else if (cfg_wr && !locked) begin
      out_en    <= wreq.data[CFG_OUT_EN];
      crit_only <= wreq.data[CFG_CRIT_ONLY];
      polarity  <= wreq.data[CFG_POLARITY];
      mode_int  <= wreq.data[CFG_MODE];
    end
  end

  // Shutdown may always be cleared, but set by host only when unlocked
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      shutdown <= 1'b0;
    end else if (force_off) begin
      shutdown <= 1'b1;
    end else if (cfg_wr) begin
      if (!wreq.data[CFG_SHUTDOWN]) begin
        shutdown <= 1'b0;
      end else if (!locked) begin
        shutdown <= 1'b1;
      end
    end
  end

  // Registered copy of shutdown, one cycle later; all logic on sys_clk keeps running
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sensor_powerdown <= 1'b0;
    end else begin
      sensor_powerdown <= shutdown;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alert generation

  assign ev_src    = ~shutdown & (crit_event | (~crit_only & window_event));
  assign alert_act = mode_int ? pending : ev_src;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ev_src_q <= 1'b0;
      pending  <= 1'b0;
    end else begin
      ev_src_q <= ev_src;
      if (!mode_int) begin
        pending <= 1'b0;
      end else if (ev_src && !ev_src_q) begin
        pending <= 1'b1;
      end else if (cfg_wr && wreq.data[CFG_CLEAR]) begin
        pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      alert_status <= 1'b0;
    end else begin
      alert_status <= alert_act & out_en;
    end
  end

  // Open drain: active-high assertion is a release, so idle is a pull-low
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      alert_o  <= 1'b0;
      alert_oe <= 1'b0;
    end else begin
      alert_o  <= 1'b0;
      alert_oe <= out_en & (alert_act ^ polarity);
    end
  end

endmodule

//--- rtl/tec_pkg.sv
// Constants and types shared by the thermal event configuration block
//Function
// - With auto turn-off on and supply good at interval end, keep sensing.
// - With auto turn-off on and supply low at interval end, force shutdown.
// - Writing zero to the shutdown bit restarts sensing.
// - Auto turn-off enable is a factory strap, invisible to host reads.
// - Critical lock resets to zero; when set, critical trip writes are ignored.
// - One write of one sets the critical lock until power-on reset.
// - Window lock resets to zero; when set, upper and lower writes ignored.
// - One write of one sets the window lock until power-on reset.
// - Writing one to clear bit drops a pending alert in interrupt mode.
// - Clear bit has no effect in comparator mode.
// - Clear bit is write-only and reads zero.
// - Status bit reads one while this device asserts the alert output.
// - Writes to the status bit are ignored.
// - Output enable resets to zero; one lets the device drive alert.
// - Either lock freezes output enable, critical-only and polarity bits.
// - Critical-only zero: window or critical events; one: critical only.
// - Polarity zero gives active-low alert, one gives active-high.
// - While shut down, sensing stays off and no events are generated.
// - Mode bit: zero comparator, one interrupt; frozen while locked.
package tec_pkg;

  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned PWRUP_TIME_MS = 30;
  localparam int unsigned PWRUP_CYCLES  = PWRUP_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned PWRUP_CNT_W   = 20;

  // Fixed upper nibble of the sensor's bus address; pins give the rest
  localparam logic [3:0]  BUS_ADDR_HI   = 4'h3;

  localparam logic [7:0]  PTR_CONFIG    = 8'h01;
  localparam logic [7:0]  PTR_UPPER     = 8'h02;
  localparam logic [7:0]  PTR_LOWER     = 8'h03;
  localparam logic [7:0]  PTR_CRIT      = 8'h04;
  localparam logic [7:0]  PTR_TEMP      = 8'h05;

  localparam logic [15:0] TRIP_RESET    = 16'h0000;
  localparam logic [15:0] TRIP_MASK     = 16'h1FFC;
  localparam logic [7:0]  PTR_RESET     = 8'h00;

  localparam int unsigned CFG_SHUTDOWN  = 8;
  localparam int unsigned CFG_CT_LOCK   = 7;
  localparam int unsigned CFG_AW_LOCK   = 6;
  localparam int unsigned CFG_CLEAR     = 5;
  localparam int unsigned CFG_STATUS    = 4;
  localparam int unsigned CFG_OUT_EN    = 3;
  localparam int unsigned CFG_CRIT_ONLY = 2;
  localparam int unsigned CFG_POLARITY  = 1;
  localparam int unsigned CFG_MODE      = 0;

  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  LAST_TX_BIT   = 4'h7;
  localparam logic [2:0]  BYTE_ADDR     = 3'h0;
  localparam logic [2:0]  BYTE_PTR      = 3'h1;
  localparam logic [2:0]  BYTE_DATA_HI  = 3'h2;
  localparam logic [2:0]  BYTE_DATA_LO  = 3'h3;
  localparam logic [2:0]  BYTE_EXTRA    = 3'h4;

  typedef struct packed {
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] critical;
  } tec_trip_t;

  typedef struct packed {
    logic [7:0]  ptr;
    logic [15:0] data;
  } tec_wreq_t;

  typedef enum logic [2:0] {
    TEC_IDLE,
    TEC_RECV,
    TEC_ACK,
    TEC_SEND,
    TEC_MACK
  } tec_phase_t;

endpackage

//--- rtl/tec_pwrup_timer.sv
// Power-up interval timer that may force the sensor into shutdown
`timescale 1ns/10ps
module tec_pwrup_timer
  import tec_pkg::*;
#(
  parameter int unsigned CNT = PWRUP_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic fuse_in,
  input  wire logic supply_in,
  output logic      force_off
);

  localparam logic [PWRUP_CNT_W-1:0] CNT_LAST = PWRUP_CNT_W'(CNT - 1);

  logic                   fuse_s1;
  logic                   fuse_s2;
  logic                   sup_s1;
  logic                   sup_s2;
  logic                   running;
  logic [PWRUP_CNT_W-1:0] cnt;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fuse_s1 <= 1'b0;
      fuse_s2 <= 1'b0;
      sup_s1  <= 1'b0;
      sup_s2  <= 1'b0;
    end else begin
      fuse_s1 <= fuse_in;
      fuse_s2 <= fuse_s1;
      sup_s1  <= supply_in;
      sup_s2  <= sup_s1;
    end
  end

  // Interval starts when reset releases, i.e. when the oscillator runs
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt       <= '0;
      running   <= 1'b1;
      force_off <= 1'b0;
    end else begin
      force_off <= 1'b0;
      if (running) begin
        if (cnt == CNT_LAST) begin
          running   <= 1'b0;
          force_off <= fuse_s2 & ~sup_s2;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end

endmodule

//--- test/tec_config_lock_properties.sv
// Port-level assertions for the thermal event configuration block
`timescale 1ns/10ps
module tec_config_lock_properties
  import tec_pkg::*;
#(
  parameter int unsigned PWRUP_CNT = PWRUP_CYCLES
) (
  input wire logic      sys_clk,
  input wire logic      arst_n,
  input wire logic      scl_i,
  input wire logic      sda_o,
  input wire logic      supply_ok,
  input wire logic      auto_off_fuse,
  input wire logic      crit_event,
  input wire logic      window_event,
  input wire logic      alert_o,
  input wire logic      alert_oe,
  input wire logic      sensor_powerdown,
  input wire tec_trip_t trip_limits
);
  int unsigned up_cyc;
  logic [3:0]  quiet;
  logic [3:0]  scl_hi;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

////////////////////////////////////////////////////////////////////////////////
  // Saturates so the power-up window test stays cheap
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      up_cyc <= 0;
    end else if (up_cyc < PWRUP_CNT + 8) begin
      up_cyc <= up_cyc + 1;
    end
  end

  // Cycles since the bus clock, an event or power state last moved
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      quiet <= 4'h0;
    end else if ($changed({scl_i, crit_event, window_event, sensor_powerdown})) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hF) begin
      quiet <= quiet + 4'h1;
    end
  end

  // Bus clock high this long means no write can still be landing
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_hi <= 4'h0;
    end else if (!scl_i) begin
      scl_hi <= 4'h0;
    end else if (scl_hi != 4'hF) begin
      scl_hi <= scl_hi + 4'h1;
    end
  end

////////////////////////////////////////////////////////////////////////////////
  property p_pins_drain;
    sda_o == 1'b0 && alert_o == 1'b0;
  endproperty
  a_pins_drain: assert property (p_pins_drain) else $error("pin driven high");

  property p_reset_vals;
    $rose(arst_n) |-> !alert_oe && trip_limits == '0;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

  property p_pd_quiet;
    sensor_powerdown[*3] ##0 scl_hi >= 4'h8 |=> $stable(alert_oe);
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("alert moved in shutdown");

  property p_oe_cause;
    $changed(alert_oe) |-> quiet < 4'hA || (up_cyc >= PWRUP_CNT && up_cyc <= PWRUP_CNT + 6);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("alert moved without cause");

  property p_trip_mask;
    ((trip_limits.upper | trip_limits.lower | trip_limits.critical) & ~TRIP_MASK) == 16'h0000;
  endproperty
  a_trip_mask: assert property (p_trip_mask) else $error("reserved trip bit set");

  property p_trip_when;
    $changed(trip_limits) |-> !scl_i;
  endproperty
  a_trip_when: assert property (p_trip_when) else $error("trip changed off a write");

  property p_pd_rise;
    $rose(sensor_powerdown) |-> !scl_i ||
      (auto_off_fuse && !supply_ok && up_cyc >= PWRUP_CNT && up_cyc <= PWRUP_CNT + 4);
  endproperty
  a_pd_rise: assert property (p_pd_rise) else $error("unexpected shutdown");

  property p_pd_fall;
    $fell(sensor_powerdown) |-> !scl_i;
  endproperty
  a_pd_fall: assert property (p_pd_fall) else $error("shutdown left off a write");

  c_forced_off: cover property ($rose(sensor_powerdown) && scl_i);
  c_alert_on: cover property ($rose(alert_oe));
  c_trip_set: cover property ($changed(trip_limits.lower));
endmodule

bind tec_config_lock tec_config_lock_properties #(
  .PWRUP_CNT(PWRUP_CNT)
) u_props (
  .sys_clk, .arst_n, .scl_i, .sda_o, .supply_ok, .auto_off_fuse, .crit_event,
  .window_event, .alert_o, .alert_oe, .sensor_powerdown, .trip_limits
);

//--- test/tec_host_model.sv
// Two-wire host model that drives the sensor's bus pins
`timescale 1ns/10ps
module tec_host_model
  import tec_pkg::*;
#(
  parameter int unsigned HALF = 8
) (
  input  wire logic sys_clk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic       pull_low;
  logic [6:0] dev_addr;
  logic       ack_ok;

  // Pull-up: a released data line reads high
  assign sda = !(pull_low || sda_oe);

  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
    dev_addr = {BUS_ADDR_HI, 3'h5};
    ack_ok = 1'b1;
  end

  task automatic wait_h();
    repeat (HALF) @(negedge sys_clk);
  endtask

  // Data moves two cycles after the clock fall, never with it
  task automatic clk_bit(input logic b, output logic s);
    repeat (2) @(negedge sys_clk);
    pull_low = !b;
    wait_h();
    scl = 1'b1;
    wait_h();
    s = sda;
    scl = 1'b0;
  endtask

  task automatic start();
    repeat (2) @(negedge sys_clk);
    pull_low = 1'b0;
    wait_h();
    scl = 1'b1;
    wait_h();
    pull_low = 1'b1;
    wait_h();
    scl = 1'b0;
  endtask

  task automatic stop();
    repeat (2) @(negedge sys_clk);
    pull_low = 1'b1;
    wait_h();
    scl = 1'b1;
    wait_h();
    pull_low = 1'b0;
    wait_h();
  endtask

  task automatic byte_tx(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, s);
    if (s !== 1'b0) begin
      ack_ok = 1'b0;
    end
  endtask

  task automatic byte_rx(output logic [7:0] b, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, b[i]);
    end
    clk_bit(last, s);
  endtask

  task automatic write_word(input logic [7:0] ptr, input logic [15:0] d);
    start();
    byte_tx({dev_addr, 1'b0});
    byte_tx(ptr);
    byte_tx(d[15:8]);
    byte_tx(d[7:0]);
    stop();
  endtask

  task automatic read_word(input logic [7:0] ptr, output logic [15:0] d);
    logic [7:0] hi;
    logic [7:0] lo;
    start();
    byte_tx({dev_addr, 1'b0});
    byte_tx(ptr);
    start();
    byte_tx({dev_addr, 1'b1});
    byte_rx(hi, 1'b0);
    byte_rx(lo, 1'b1);
    stop();
    d = {hi, lo};
  endtask
endmodule

//--- test/testbench.sv
// Self-checking bench for the configuration and lock block
`timescale 1ns/10ps
module testbench;
  import tec_pkg::*;
  localparam int unsigned PCNT = 50;
  typedef struct packed {
    logic [15:0] wr;
    logic        crit;
    logic        win;
    logic [15:0] rd;
    logic        oe;
  } tec_row_t;
  logic        sys_clk, arst_n, scl_i, sda_i, sda_o, sda_oe, alert_o, alert_oe;
  logic        supply_ok, auto_off_fuse, crit_event, window_event, sensor_powerdown;
  logic [2:0]  addr_pins;
  logic [15:0] temp_value, d;
  tec_trip_t   trip_limits;
  int          bad_count = 0;
  int          check_count = 0;
  logic [2:0]  pu [3] = '{3'h5, 3'h6, 3'h0};
  tec_row_t    rows [11] = '{
    {16'h0000, 2'h0, 16'h0000, 1'h0},
    {16'h0008, 2'h0, 16'h0008, 1'h0},
    {16'h0008, 2'h1, 16'h0018, 1'h1},
    {16'h000C, 2'h1, 16'h000C, 1'h0},
    {16'h000C, 2'h2, 16'h001C, 1'h1},
    {16'h000A, 2'h0, 16'h000A, 1'h1},
    {16'h000A, 2'h2, 16'h001A, 1'h0},
    {16'h0002, 2'h1, 16'h0002, 1'h0},
    {16'h0038, 2'h1, 16'h0018, 1'h1},
    {16'h0108, 2'h1, 16'h0108, 1'h0},
    {16'h0008, 2'h1, 16'h0018, 1'h1}};

  tec_config_lock #(.PWRUP_CNT(PCNT)) dut (
    .sys_clk, .arst_n, .scl_i, .sda_i, .sda_o, .sda_oe, .addr_pins, .supply_ok,
    .auto_off_fuse, .crit_event, .window_event, .temp_value, .alert_o, .alert_oe,
    .sensor_powerdown, .trip_limits);
  tec_host_model host (.sys_clk, .sda_oe, .scl(scl_i), .sda(sda_i));

////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic do_reset();
    arst_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Whole run needs about 39k cycles
  initial begin
    #5_000_000;
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end

////////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    addr_pins = 3'h5;
    supply_ok = 1'b1;
    auto_off_fuse = 1'b0;
    crit_event = 1'b0;
    window_event = 1'b0;
    temp_value = 16'h0190;
    do_reset();
    check(16'(alert_oe), 16'h0000, "reset alert");
    host.read_word(PTR_CONFIG, d);
    check(d, 16'h0000, "reset config");
    foreach (rows[i]) begin
      {crit_event, window_event} = {rows[i].crit, rows[i].win};
      host.write_word(PTR_CONFIG, rows[i].wr);
      repeat (4) @(negedge sys_clk);
      check(16'(alert_oe), 16'(rows[i].oe), "row alert");
      check(16'(sensor_powerdown), 16'(rows[i].rd[8]), "row shutdown");
      host.read_word(PTR_CONFIG, d);
      check(d, rows[i].rd, "row config");
    end
    $display("%0t table done", $time);
    window_event = 1'b0;
    host.write_word(PTR_CONFIG, 16'h0009);
    window_event = 1'b1;
    repeat (4) @(negedge sys_clk);
    window_event = 1'b0;
    repeat (4) @(negedge sys_clk);
    check(16'(alert_oe), 16'h0001, "latched");
    host.write_word(PTR_CONFIG, 16'h0009);
    check(16'(alert_oe), 16'h0001, "zero clear");
    host.write_word(PTR_CONFIG, 16'h0029);
    check(16'(alert_oe), 16'h0000, "cleared");
    host.read_word(PTR_CONFIG, d);
    check(d, 16'h0009, "clear reads zero");
    $display("%0t interrupt done", $time);
    host.write_word(PTR_UPPER, 16'hFFFF);
    check(trip_limits.upper, TRIP_MASK, "upper written");
    host.write_word(PTR_CRIT, 16'hE7D1);
    check(trip_limits.critical, 16'h07D0, "critical open");
    // Critical lock goes first so the window lock is never set alone
    host.write_word(PTR_CONFIG, 16'h0089);
    host.write_word(PTR_CRIT, 16'h0ABC);
    check(trip_limits.critical, 16'h07D0, "critical locked");
    host.write_word(PTR_LOWER, 16'h0ABC);
    check(trip_limits.lower, 16'h0ABC, "lower open");
    host.write_word(PTR_CONFIG, 16'h0146);
    host.read_word(PTR_CONFIG, d);
    check(d, 16'h00C9, "bits frozen");
    host.write_word(PTR_CONFIG, 16'h0000);
    host.read_word(PTR_CONFIG, d);
    check(d, 16'h00C9, "locks held");
    host.write_word(PTR_UPPER, 16'h0004);
    check(trip_limits.upper, TRIP_MASK, "upper locked");
    host.write_word(PTR_LOWER, 16'h0004);
    check(trip_limits.lower, 16'h0ABC, "lower locked");
    do_reset();
    check(trip_limits.upper | trip_limits.lower | trip_limits.critical,
          TRIP_RESET, "trip reset");
    host.read_word(PTR_CONFIG, d);
    check(d, 16'h0000, "locks reset");
    $display("%0t locks done", $time);
    for (int k = 0; k < 3; k++) begin
      {auto_off_fuse, supply_ok} = pu[k][2:1];
      do_reset();
      repeat (PCNT + 8) @(negedge sys_clk);
      check(16'(sensor_powerdown), 16'(pu[k][0]), "power-up");
      supply_ok = 1'b1;
      host.read_word(PTR_CONFIG, d);
      check(d, {7'h00, pu[k][0], 8'h00}, "power-up config");
      host.write_word(PTR_CONFIG, 16'h0000);
      check(16'(sensor_powerdown), 16'h0000, "restart");
    end
    $display("%0t power-up done", $time);
    check(16'(host.ack_ok), 16'h0001, "acks so far");
    host.dev_addr = {BUS_ADDR_HI, 3'h2};
    host.write_word(PTR_CONFIG, 16'h0008);
    check(16'(host.ack_ok), 16'h0000, "foreign address");
    host.dev_addr = {BUS_ADDR_HI, 3'h5};
    host.ack_ok = 1'b1;
    host.read_word(PTR_CONFIG, d);
    check(d, 16'h0000, "foreign write");
    host.read_word(PTR_TEMP, d);
    check(d, 16'h0190, "temperature");
    host.read_word(8'h07, d);
    check(d, 16'h0000, "unmapped");
    check(16'(host.ack_ok), 16'h0001, "acks");
    $display("%0t bus done", $time);
    results();
  end
endmodule
